// ---- common/crpr_consts.svh ----
`ifndef CRPR_CONSTS_SVH
`define CRPR_CONSTS_SVH

// Register indices; byte address is four times the index
`define CRPR_IDX_LOC_B0_A4 10'h192
`define CRPR_IDX_LOC_B2_B1 10'h193
`define CRPR_IDX_LOC_B4_B3 10'h194
`define CRPR_IDX_LOC_C1_C0 10'h195
`define CRPR_IDX_LOC_C3_C2 10'h196
`define CRPR_IDX_LOC_D0_C4 10'h197
`define CRPR_IDX_LOC_D2_D1 10'h198
`define CRPR_IDX_LOC_D4_D3 10'h199
`define CRPR_IDX_AMP_A1_A0 10'h19a
`define CRPR_IDX_CTRL 10'h1b0
`define CRPR_IDX_STATUS 10'h1b1

// Result word layout
`define CRPR_NUM_WORDS 9
`define CRPR_SLOT_AMP 4'h8
`define CRPR_LOC_MASK 16'hffff
`define CRPR_AMP_MASK 16'h7f7f
`define CRPR_WORD_RESET 16'h0000

// Control and status fields
`define CRPR_CTRL_CAPTURE_BIT 0
`define CRPR_CTRL_RESET 1'b1
`define CRPR_STAT_VALID_BIT 0
`define CRPR_STAT_COUNT_LSB 8
`define CRPR_COUNT_RESET 8'h00

`endif

// ---- common/crpr_pkg.sv ----
package crpr_pkg;
	typedef logic [15:0] crpr_word_t;
	typedef logic [9:0] crpr_idx_t;
	typedef logic [3:0] crpr_slot_t;
	typedef enum logic [0:0] {
		CRPR_IDLE,
		CRPR_RESP
	} crpr_apb_e;
endpackage : crpr_pkg

// ---- common/crpr_reg_if.sv ----
`timescale 1ns/1ps
interface crpr_reg_if;
	crpr_pkg::crpr_idx_t idx;
	logic wr;
	logic [31:0] wdata;
	logic commit;
	logic [31:0] rdata;
	logic err;
	modport port (output idx, output wr, output wdata, output commit, input rdata, input err);
	modport regs (input idx, input wr, input wdata, input commit, output rdata, output err);
endinterface : crpr_reg_if

// ---- logic/crpr_apb_port.sv ----
`timescale 1ns/1ps
`include "crpr_consts.svh"
module crpr_apb_port (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// APB
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Register side
	crpr_reg_if.port reg_if
);
	crpr_pkg::crpr_apb_e state;
	crpr_pkg::crpr_apb_e next_state;
	logic setup;
	logic misaligned;

	assign setup = psel_i && !penable_i;
	assign misaligned = paddr_i[1:0] != 2'h0;
	assign reg_if.idx = paddr_i[11:2];
	assign reg_if.wr = pwrite_i;
	assign reg_if.wdata = pwdata_i;
	// A write lands only at the edge that completes the access
	assign reg_if.commit = psel_i && penable_i && pready_o && !misaligned;

	always_comb begin
		case (state)
			crpr_pkg::CRPR_IDLE: next_state = setup ? crpr_pkg::CRPR_RESP : crpr_pkg::CRPR_IDLE;
			crpr_pkg::CRPR_RESP: next_state = crpr_pkg::CRPR_IDLE;
			default: next_state = crpr_pkg::CRPR_IDLE;
		endcase
	end

	// Answer is prepared in the setup cycle, so the access phase never waits
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= crpr_pkg::CRPR_IDLE;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0;
		end else begin
			state <= next_state;
			pready_o <= next_state == crpr_pkg::CRPR_RESP;
			if (next_state == crpr_pkg::CRPR_RESP) begin
				pslverr_o <= reg_if.err || misaligned;
				prdata_o <= (pwrite_i || misaligned) ? 32'h0 : reg_if.rdata;
			end else begin
				pslverr_o <= 1'b0;
				prdata_o <= 32'h0;
			end
		end
	end
endmodule : crpr_apb_port

// ---- logic/crpr_result_store.sv ----
`timescale 1ns/1ps
`include "crpr_consts.svh"
module crpr_result_store (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Capture side
	input wire logic load_i,
	input wire logic [`CRPR_NUM_WORDS*16-1:0] words_i,
	// Read side
	output logic [`CRPR_NUM_WORDS*16-1:0] words_o
);
	crpr_pkg::crpr_word_t store [0:`CRPR_NUM_WORDS-1];

	genvar g;
	generate
		for (g = 0; g < `CRPR_NUM_WORDS; g++) begin : g_word
			localparam crpr_pkg::crpr_word_t MASK = (g == `CRPR_SLOT_AMP) ? `CRPR_AMP_MASK : `CRPR_LOC_MASK;
			// Reserved bits never get stored, so they read as zero
			always_ff @(posedge clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					store[g] <= `CRPR_WORD_RESET;
				end else if (load_i) begin
					store[g] <= words_i[g*16 +: 16] & MASK;
				end
			end
			assign words_o[g*16 +: 16] = store[g];
		end
	endgenerate
endmodule : crpr_result_store

// ---- logic/crpr_top.sv ----
`timescale 1ns/1ps
`include "crpr_consts.svh"
module crpr_top (
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RESETN_I,
	// APB slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// Measurement engine results
	input wire logic MEAS_DONE_I,
	input wire logic [7:0] LOC_CHAN_A_PEAK5_I,
	input wire logic [39:0] LOC_CHAN_B_I,
	input wire logic [39:0] LOC_CHAN_C_I,
	input wire logic [39:0] LOC_CHAN_D_I,
	input wire logic [13:0] AMP_CHAN_A_I,
	// Status
	output logic RESULTS_VALID_O
);
	crpr_reg_if reg_if ();

	logic capture_en;
	logic [7:0] meas_count;
	logic load;
	logic ctrl_wr;
	logic [`CRPR_NUM_WORDS*16-1:0] next_words;
	logic [`CRPR_NUM_WORDS*16-1:0] words;
	crpr_pkg::crpr_word_t w [0:`CRPR_NUM_WORDS-1];
	crpr_pkg::crpr_word_t ctrl_word;
	crpr_pkg::crpr_word_t status_word;
	crpr_pkg::crpr_word_t sel_word;
	logic sel_hit;
	logic [`CRPR_NUM_WORDS-1:0] hit_word;
	crpr_pkg::crpr_word_t pick [0:`CRPR_NUM_WORDS];
	logic hit_ctrl;
	logic hit_status;

	// Split the engine's location vectors into peaks 1..5 (bytes 0..4), and the amplitude vector into 7-bit peaks 1..2
	logic [7:0] loc_chan_a_peak5;
	logic [7:0] loc_chan_b_peak1, loc_chan_b_peak2, loc_chan_b_peak3, loc_chan_b_peak4, loc_chan_b_peak5;
	logic [7:0] loc_chan_c_peak1, loc_chan_c_peak2, loc_chan_c_peak3, loc_chan_c_peak4, loc_chan_c_peak5;
	logic [7:0] loc_chan_d_peak1, loc_chan_d_peak2, loc_chan_d_peak3, loc_chan_d_peak4, loc_chan_d_peak5;
	logic [6:0] amp_chan_a_peak1, amp_chan_a_peak2;

	assign loc_chan_a_peak5 = LOC_CHAN_A_PEAK5_I;
	assign loc_chan_b_peak1 = LOC_CHAN_B_I[7:0];
	assign loc_chan_b_peak2 = LOC_CHAN_B_I[15:8];
	assign loc_chan_b_peak3 = LOC_CHAN_B_I[23:16];
	assign loc_chan_b_peak4 = LOC_CHAN_B_I[31:24];
	assign loc_chan_b_peak5 = LOC_CHAN_B_I[39:32];
	assign loc_chan_c_peak1 = LOC_CHAN_C_I[7:0];
	assign loc_chan_c_peak2 = LOC_CHAN_C_I[15:8];
	assign loc_chan_c_peak3 = LOC_CHAN_C_I[23:16];
	assign loc_chan_c_peak4 = LOC_CHAN_C_I[31:24];
	assign loc_chan_c_peak5 = LOC_CHAN_C_I[39:32];
	assign loc_chan_d_peak1 = LOC_CHAN_D_I[7:0];
	assign loc_chan_d_peak2 = LOC_CHAN_D_I[15:8];
	assign loc_chan_d_peak3 = LOC_CHAN_D_I[23:16];
	assign loc_chan_d_peak4 = LOC_CHAN_D_I[31:24];
	assign loc_chan_d_peak5 = LOC_CHAN_D_I[39:32];
	assign amp_chan_a_peak1 = AMP_CHAN_A_I[6:0];
	assign amp_chan_a_peak2 = AMP_CHAN_A_I[13:7];

	// Pack into register layout, slot order follows the index order
	assign next_words[0*16 +: 16] = {loc_chan_b_peak1, loc_chan_a_peak5};
	assign next_words[1*16 +: 16] = {loc_chan_b_peak3, loc_chan_b_peak2};
	assign next_words[2*16 +: 16] = {loc_chan_b_peak5, loc_chan_b_peak4};
	assign next_words[3*16 +: 16] = {loc_chan_c_peak2, loc_chan_c_peak1};
	assign next_words[4*16 +: 16] = {loc_chan_c_peak4, loc_chan_c_peak3};
	assign next_words[5*16 +: 16] = {loc_chan_d_peak1, loc_chan_c_peak5};
	assign next_words[6*16 +: 16] = {loc_chan_d_peak3, loc_chan_d_peak2};
	assign next_words[7*16 +: 16] = {loc_chan_d_peak5, loc_chan_d_peak4};
	assign next_words[8*16 +: 16] = {1'b0, amp_chan_a_peak2, 1'b0, amp_chan_a_peak1};

	// Results move only on a completed measurement while capture is enabled
	assign load = MEAS_DONE_I && capture_en;

	crpr_result_store u_store (
		.clk_i(CLOCK_I),
		.resetn_i(RESETN_I),
		.load_i(load),
		.words_i(next_words),
		.words_o(words)
	);

	crpr_apb_port u_apb (
		.clk_i(CLOCK_I),
		.resetn_i(RESETN_I),
		.psel_i(PSEL_I),
		.penable_i(PENABLE_I),
		.pwrite_i(PWRITE_I),
		.paddr_i(PADDR_I),
		.pwdata_i(PWDATA_I),
		.prdata_o(PRDATA_O),
		.pready_o(PREADY_O),
		.pslverr_o(PSLVERR_O),
		.reg_if(reg_if.port)
	);

	// Result indices are consecutive, one slot each; the chain ORs in the selected slot
	assign pick[0] = 16'h0000;
	genvar g;
	generate
		for (g = 0; g < `CRPR_NUM_WORDS; g++) begin : g_view
			localparam crpr_pkg::crpr_idx_t IDX = crpr_pkg::crpr_idx_t'(`CRPR_IDX_LOC_B0_A4 + g);
			assign w[g] = words[g*16 +: 16];
			assign hit_word[g] = reg_if.idx == IDX;
			assign pick[g + 1] = pick[g] | (hit_word[g] ? w[g] : 16'h0000);
		end
	endgenerate

	assign ctrl_word = {15'h0000, capture_en};
	assign status_word = {meas_count, 7'h00, RESULTS_VALID_O};

	// Read decode; result words carry no write path at all
	assign hit_ctrl = reg_if.idx == `CRPR_IDX_CTRL;
	assign hit_status = reg_if.idx == `CRPR_IDX_STATUS;
	assign sel_hit = |hit_word || hit_ctrl || hit_status;
	assign sel_word = hit_ctrl ? ctrl_word : (hit_status ? status_word : pick[`CRPR_NUM_WORDS]);

	assign reg_if.rdata = {16'h0000, sel_word};
	assign reg_if.err = !sel_hit;
	assign ctrl_wr = reg_if.commit && reg_if.wr && hit_ctrl;

	always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			capture_en <= `CRPR_CTRL_RESET;
			meas_count <= `CRPR_COUNT_RESET;
			RESULTS_VALID_O <= 1'b0;
		end else begin
			if (ctrl_wr) begin
				capture_en <= reg_if.wdata[`CRPR_CTRL_CAPTURE_BIT];
			end
			if (load) begin
				meas_count <= meas_count + 8'h01;
				RESULTS_VALID_O <= 1'b1;
			end
		end
	end

	// Checks
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RESETN_I);

	logic rd_done;
	logic wr_done;
	assign rd_done = PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I && !PSLVERR_O;
	assign wr_done = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
	logic rd_setup;
	logic wr_setup;
	assign rd_setup = PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I[1:0] == 2'h0;
	assign wr_setup = PSEL_I && !PENABLE_I && PWRITE_I && PADDR_I[1:0] == 2'h0;

	a_word0_layout: assert property (load |=> w[0] == {$past(LOC_CHAN_B_I[7:0]), $past(LOC_CHAN_A_PEAK5_I)})
		else $error("word 0x192 layout wrong");
	a_word1_layout: assert property (load |=> w[1] == $past(LOC_CHAN_B_I[23:8]))
		else $error("word 0x193 layout wrong");
	a_word2_layout: assert property (load |=> w[2] == $past(LOC_CHAN_B_I[39:24]))
		else $error("word 0x194 layout wrong");
	a_word3_layout: assert property (load |=> w[3] == $past(LOC_CHAN_C_I[15:0]))
		else $error("word 0x195 layout wrong");
	a_word4_layout: assert property (load |=> w[4] == $past(LOC_CHAN_C_I[31:16]))
		else $error("word 0x196 layout wrong");
	a_word5_layout: assert property (load |=> w[5] == {$past(LOC_CHAN_D_I[7:0]), $past(LOC_CHAN_C_I[39:32])})
		else $error("word 0x197 layout wrong");
	a_word6_layout: assert property (load |=> w[6] == $past(LOC_CHAN_D_I[23:8]))
		else $error("word 0x198 layout wrong");
	a_word7_layout: assert property (load |=> w[7] == $past(LOC_CHAN_D_I[39:24]))
		else $error("word 0x199 layout wrong");
	a_loc_write_ignored: assert property (wr_done && !MEAS_DONE_I |=> $stable(words))
		else $error("write changed a result word");
	a_amp_layout: assert property (load |=> w[8][14:8] == $past(AMP_CHAN_A_I[13:7]) && w[8][6:0] == $past(AMP_CHAN_A_I[6:0]))
		else $error("amplitude word layout wrong");
	a_amp_reserved: assert property (rd_done && $past(PADDR_I[11:2]) == `CRPR_IDX_AMP_A1_A0 |-> PRDATA_O[15] == 1'b0 && PRDATA_O[7] == 1'b0)
		else $error("amplitude reserved bit read as one");
	a_hold_between: assert property (!load |=> $stable(words))
		else $error("results moved without a measurement");
	a_read_path: assert property (PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I[11:2] == `CRPR_IDX_LOC_B0_A4 && PADDR_I[1:0] == 2'h0
		|=> PREADY_O && PRDATA_O == {16'h0000, $past(w[0])})
		else $error("read of 0x192 returned wrong data");

	// Every readable index answers with the word that stood at the setup edge
	a_read_w1: assert property (rd_setup && hit_word[1]
		|=> PREADY_O && PRDATA_O == {16'h0000, $past(w[1])})
		else $error("read of index 0x193 returned wrong data");
	a_read_w2: assert property (rd_setup && hit_word[2]
		|=> PREADY_O && PRDATA_O == {16'h0000, $past(w[2])})
		else $error("read of index 0x194 returned wrong data");
	a_read_w3: assert property (rd_setup && hit_word[3]
		|=> PREADY_O && PRDATA_O == {16'h0000, $past(w[3])})
		else $error("read of index 0x195 returned wrong data");
	a_read_w4: assert property (rd_setup && hit_word[4]
		|=> PREADY_O && PRDATA_O == {16'h0000, $past(w[4])})
		else $error("read of index 0x196 returned wrong data");
	a_read_w5: assert property (rd_setup && hit_word[5]
		|=> PREADY_O && PRDATA_O == {16'h0000, $past(w[5])})
		else $error("read of index 0x197 returned wrong data");
	a_read_w6: assert property (rd_setup && hit_word[6]
		|=> PREADY_O && PRDATA_O == {16'h0000, $past(w[6])})
		else $error("read of index 0x198 returned wrong data");
	a_read_w7: assert property (rd_setup && hit_word[7]
		|=> PREADY_O && PRDATA_O == {16'h0000, $past(w[7])})
		else $error("read of index 0x199 returned wrong data");
	a_read_w8: assert property (rd_setup && hit_word[8]
		|=> PREADY_O && PRDATA_O == {16'h0000, $past(w[8])})
		else $error("read of index 0x19a returned wrong data");
	a_read_ctrl: assert property (rd_setup && hit_ctrl
		|=> PREADY_O && PRDATA_O == {16'h0000, $past(ctrl_word)})
		else $error("read of control word returned wrong data");
	a_read_status: assert property (rd_setup && hit_status
		|=> PREADY_O && PRDATA_O == {16'h0000, $past(status_word)})
		else $error("read of status word returned wrong data");

	// Bus answer timing and error reporting
	a_setup_answer: assert property (PSEL_I && !PENABLE_I
		|=> PREADY_O)
		else $error("setup not answered in the access phase");
	a_idle_quiet: assert property (!PSEL_I
		|=> !PREADY_O)
		else $error("ready without a select");
	a_ready_single: assert property (PREADY_O
		|=> !PREADY_O)
		else $error("ready stood for more than one cycle");
	a_ready_after_setup: assert property (PREADY_O
		|-> $past(PSEL_I) && !$past(PENABLE_I))
		else $error("ready without a preceding setup");
	a_err_needs_ready: assert property (PSLVERR_O
		|-> PREADY_O)
		else $error("error flag outside an answer");
	a_err_data_zero: assert property (PSLVERR_O
		|-> PRDATA_O == 32'h0)
		else $error("error answer carried data");
	a_rdata_quiet: assert property (!PREADY_O
		|-> PRDATA_O == 32'h0)
		else $error("read data outside an answer");
	a_rdata_upper: assert property (PREADY_O
		|-> PRDATA_O[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	a_unmapped_err: assert property (PSEL_I && !PENABLE_I && !sel_hit
		|=> PREADY_O && PSLVERR_O)
		else $error("unmapped index answered without error");
	a_misaligned_err: assert property (PSEL_I && !PENABLE_I && PADDR_I[1:0] != 2'h0
		|=> PREADY_O && PSLVERR_O)
		else $error("misaligned address answered without error");
	a_write_no_data: assert property (PSEL_I && !PENABLE_I && PWRITE_I
		|=> PRDATA_O == 32'h0)
		else $error("write answer carried data");
	a_ro_write_ok: assert property (wr_setup && |hit_word
		|=> PREADY_O && !PSLVERR_O)
		else $error("write to a result word reported an error");
	a_ctrl_write_ok: assert property (wr_setup && hit_ctrl
		|=> PREADY_O && !PSLVERR_O)
		else $error("write to the control word reported an error");
	a_ctrl_write: assert property (ctrl_wr
		|=> capture_en == $past(reg_if.wdata[`CRPR_CTRL_CAPTURE_BIT]))
		else $error("control write did not land");
	a_misaligned_no_write: assert property (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I[1:0] != 2'h0
		|=> $stable(capture_en))
		else $error("misaligned write changed the control word");

	// Capture bookkeeping
	a_capture_count: assert property (load
		|=> meas_count == $past(meas_count) + 8'h01)
		else $error("capture count did not step");
	a_count_hold: assert property (!load
		|=> $stable(meas_count))
		else $error("capture count moved without a capture");
	a_valid_on_capture: assert property (load
		|=> RESULTS_VALID_O)
		else $error("valid not set by a capture");
	a_valid_sticky: assert property (RESULTS_VALID_O
		|=> RESULTS_VALID_O)
		else $error("valid dropped without reset");
	a_disabled_drop: assert property (MEAS_DONE_I && !capture_en
		|=> $stable(words))
		else $error("results moved while capture disabled");
	a_amp_stored_zero: assert property (w[8][15] == 1'b0 && w[8][7] == 1'b0)
		else $error("amplitude reserved bit stored as one");

	c_read_result: cover property (rd_done && PRDATA_O != 32'h0);
	c_capture: cover property (load ##[1:20] rd_done);
	c_ro_write: cover property (wr_done && PADDR_I[11:2] == `CRPR_IDX_LOC_D4_D3);
	c_unmapped: cover property (PREADY_O && PSLVERR_O);
	c_disabled_drop: cover property (MEAS_DONE_I && !capture_en);
endmodule : crpr_top

// ---- testbench/crpr_top_tb.sv ----
`timescale 1ns/1ps
module crpr_top_tb;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic meas = 1'b0;
	logic [7:0] a5 = 8'h00;
	logic [39:0] b = 40'h0;
	logic [39:0] c = 40'h0;
	logic [39:0] d = 40'h0;
	logic [13:0] amp = 14'h0;
	logic [31:0] rd;
	logic err;
	logic [31:0] snap [9];
	int fails = 0;
	int samples_checked = 0;
	int cycles = 0;
	wire logic [31:0] PRDATA_O;
	wire logic PREADY_O;
	wire logic PSLVERR_O;
	wire logic RESULTS_VALID_O;

	crpr_top uut (.CLOCK_I(clk), .RESETN_I(resetn), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
		.MEAS_DONE_I(meas), .LOC_CHAN_A_PEAK5_I(a5), .LOC_CHAN_B_I(b), .LOC_CHAN_C_I(c), .LOC_CHAN_D_I(d),
		.AMP_CHAN_A_I(amp), .RESULTS_VALID_O(RESULTS_VALID_O));

	always #5 clk = ~clk;

	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : finish_test

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fails++;
			finish_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
		end
	endtask : chk

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (PREADY_O !== 1'b1) @(posedge clk);
		rd = PRDATA_O;
		err = PSLVERR_O;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic pulse(input logic [7:0] na, input logic [39:0] nb, input logic [39:0] nc,
		input logic [39:0] nd, input logic [13:0] nm);
		@(posedge clk);
		a5 <= na;
		b <= nb;
		c <= nc;
		d <= nd;
		amp <= nm;
		meas <= 1'b1;
		@(posedge clk);
		meas <= 1'b0;
	endtask : pulse

	function automatic logic [31:0] exp_word(input int i);
		logic [15:0] w;
		case (i)
			0: w = {b[7:0], a5};
			1: w = {b[23:16], b[15:8]};
			2: w = {b[39:32], b[31:24]};
			3: w = {c[15:8], c[7:0]};
			4: w = {c[31:24], c[23:16]};
			5: w = {d[7:0], c[39:32]};
			6: w = {d[23:16], d[15:8]};
			7: w = {d[39:32], d[31:24]};
			default: w = {1'b0, amp[13:7], 1'b0, amp[6:0]};
		endcase
		return {16'h0000, w};
	endfunction : exp_word

	task automatic check_words(input string msg);
		for (int i = 0; i < 9; i++) begin
			apb(1'b0, 12'h648 + 12'(4 * i), 32'h0);
			chk(rd, exp_word(i), msg);
		end
	endtask : check_words

	task automatic t_reset_values();
		check_words("reset word");
		apb(1'b0, 12'h6c4, 32'h0);
		chk(rd, 32'h0, "status after reset");
		apb(1'b0, 12'h6c0, 32'h0);
		chk(rd, 32'h1, "control after reset");
	endtask : t_reset_values

	task automatic t_capture();
		pulse(8'h15, 40'hb5b4b3b2b1, 40'hc5c4c3c2c1, 40'hd5d4d3d2d1, 14'h3fff);
		check_words("captured word");
		apb(1'b1, 12'h6c4, 32'hffff_ffff);
		apb(1'b0, 12'h6c4, 32'h0);
		chk(rd, 32'h101, "status after capture");
		chk({31'h0, RESULTS_VALID_O}, 32'h1, "valid after capture");
		@(posedge clk);
		chk({PREADY_O, PRDATA_O[30:0]}, 32'h0, "answer stood past its cycle");
	endtask : t_capture

	task automatic t_write_ignored();
		for (int i = 0; i < 9; i++) begin
			apb(1'b1, 12'h648 + 12'(4 * i), 32'h5a5a_a5a5);
			chk({31'h0, err}, 32'h0, "write error flag");
		end
		check_words("word after write");
	endtask : t_write_ignored

	task automatic t_hold_disabled();
		apb(1'b1, 12'h6c0, 32'h0);
		for (int i = 0; i < 9; i++) snap[i] = exp_word(i);
		pulse(8'hea, 40'h4a4b4c4d4e, 40'h3a3b3c3d3e, 40'h2a2b2c2d2e, 14'h1555);
		for (int i = 0; i < 9; i++) begin
			apb(1'b0, 12'h648 + 12'(4 * i), 32'h0);
			chk(rd, snap[i], "word changed while disabled");
		end
		apb(1'b1, 12'h6c0, 32'h1);
		pulse(8'h81, 40'h0102030405, 40'h8090a0b0c0, 40'hf0e0d0c0b0, 14'h2aaa);
		check_words("recaptured word");
	endtask : t_hold_disabled

	task automatic t_unmapped();
		apb(1'b0, 12'h66c, 32'h0);
		chk({err, rd[30:0]}, 32'h8000_0000, "unmapped read");
		apb(1'b0, 12'h649, 32'h0);
		chk({31'h0, err}, 32'h1, "misaligned read");
		apb(1'b1, 12'h6c1, 32'h0);
		chk({31'h0, err}, 32'h1, "misaligned write");
		apb(1'b0, 12'h6c0, 32'h0);
		chk(rd, 32'h1, "control after misaligned write");
	endtask : t_unmapped

	task automatic t_mid_reset();
		@(posedge clk);
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		chk({31'h0, RESULTS_VALID_O}, 32'h0, "valid after reset");
		for (int i = 0; i < 9; i++) begin
			apb(1'b0, 12'h648 + 12'(4 * i), 32'h0);
			chk(rd, 32'h0, "word after second reset");
		end
	endtask : t_mid_reset

	initial begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		t_reset_values();
		t_capture();
		t_write_ignored();
		t_hold_disabled();
		t_unmapped();
		t_mid_reset();
		finish_test();
	end
endmodule : crpr_top_tb
